// file: logic/ffp_core.sv
`timescale 1ns/1ps
`include "ffp_cfg.svh"

module ffp_core
#(
  parameter int LOG2N      = `FFP_LOG2N_DEF,
  parameter int IN_W       = `FFP_IN_W_DEF,
  parameter int IN_FRAC    = `FFP_IN_W_DEF - 1,
  parameter bit SCALED     = 1'b1,
  parameter bit NATURAL    = 1'b1,
  parameter bit OPT_AREA   = 1'b0,
  parameter int RATE_RATIO = 1,
  parameter bit IS_FLOAT   = 1'b0,
  parameter bit USE_SOF    = 1'b0,
  parameter int TW_W       = `FFP_TW_W
)
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // sample streams
  ffp_link.dev             lnk,
  // configuration report
  output wire logic [31:0] latency,
  output wire logic        arch_burst
);

  localparam int N    = 1 << LOG2N;
  localparam int HALF = N / 2;
  localparam int AW   = LOG2N;
  localparam int BW   = LOG2N - 1;
  localparam int GW   = `FFP_STAGE_W;
  localparam ffp_pkg::ffp_arch_t ARCH =
    (OPT_AREA && RATE_RATIO == `FFP_AREA_RATE) ? ffp_pkg::ARCH_BURST : ffp_pkg::ARCH_STREAM;
  // streaming runs two butterflies a cycle, burst one: area traded for rate
  localparam int LANES = (ARCH == ffp_pkg::ARCH_BURST) ? 1 : 2;
  localparam int CPS   = HALF / LANES;
  localparam bit SOF_OK = USE_SOF && (ARCH == ffp_pkg::ARCH_STREAM) && !IS_FLOAT;
  // one guard bit when scaled, full growth when not
  localparam int DW = IN_W + (SCALED ? 1 : LOG2N + 1);
  localparam int PW = DW + TW_W;

  // index reversal for loading and for reversed output
  function automatic logic [AW-1:0] bit_rev(input logic [AW-1:0] v);
    logic [AW-1:0] r;
    r = '0;
    for (int i = 0; i < AW; i++)
      r[i] = v[AW-1-i];
    return r;
  endfunction

  // upper address of butterfly j in stage s
  function automatic logic [AW-1:0] pair_top(input logic [BW-1:0] j, input logic [GW-1:0] s);
    logic [AW-1:0] jw;
    logic [AW-1:0] low;
    jw  = {1'b0, j};
    low = jw & ((AW'(1) << s) - AW'(1));
    return ((jw >> s) << (s + 1'b1)) | low;
  endfunction

  // single precision to signed fixed with IN_FRAC fraction bits
  function automatic logic signed [IN_W-1:0] f2fix(input logic [31:0] f);
    logic [63:0]        m;
    logic signed [63:0] v;
    int                 sh;
    m  = {40'h0, (f[30:23] != 8'h00), f[22:0]};
    sh = int'(f[30:23]) - `FFP_FLOAT_BIAS - `FFP_FLOAT_MANT + IN_FRAC;
    if (f[30:23] == 8'h00)
      v = '0;
    else if (sh >= 0)
      v = signed'(m << sh);
    else
      v = signed'(m >> (-sh));
    if (f[31])
      v = -v;
    return IN_W'(v);
  endfunction

  ffp_pkg::ffp_state_t state;
  ffp_pkg::ffp_state_t next_state;
  logic [AW-1:0]       cnt;
  logic [GW-1:0]       stage;
  logic [BW-1:0]       bidx;
  logic                drop_first;
  logic signed [DW-1:0] mem_re [N];
  logic signed [DW-1:0] mem_im [N];
  logic signed [TW_W-1:0] tw_re [HALF];
  logic signed [TW_W-1:0] tw_im [HALF];
  logic [AW-1:0]        lt_addr [LANES];
  logic [AW-1:0]        lb_addr [LANES];
  logic signed [DW-1:0] nt_re [LANES];
  logic signed [DW-1:0] nt_im [LANES];
  logic signed [DW-1:0] nb_re [LANES];
  logic signed [DW-1:0] nb_im [LANES];
  logic [DW-1:0]        b_re [2];
  logic [DW-1:0]        b_im [2];
  logic [1:0]           b_sof;
  logic [1:0]           fill;
  logic                 wp;
  logic                 rp;

  // twiddles exp(-j*2*pi*k/N), unity at 2**(TW_W-2)
  for (genvar k = 0; k < HALF; k++)
  begin : g_tw
    localparam real ANG = 2.0 * `FFP_PI * k / N;
    assign tw_re[k] = TW_W'($rtoi($cos(ANG) * (2.0 ** (TW_W - 2))));
    assign tw_im[k] = TW_W'(-$rtoi($sin(ANG) * (2.0 ** (TW_W - 2))));
  end

  // input conversion: float or fixed, sign-extended into the work width
  wire logic signed [IN_W-1:0] in_fx_re =
    IS_FLOAT ? f2fix(32'(lnk.in_re)) : IN_W'(lnk.in_re);
  wire logic signed [IN_W-1:0] in_fx_im =
    IS_FLOAT ? f2fix(32'(lnk.in_im)) : IN_W'(lnk.in_im);
  wire logic signed [DW-1:0] in_ext_re = DW'(in_fx_re);
  wire logic signed [DW-1:0] in_ext_im = DW'(in_fx_im);

  // load control; with USE_SOF in the streaming fixed-point engine, a frame begin pulse restarts the frame at index 0
  assign lnk.in_ready = (state == ffp_pkg::S_LOAD);
  wire logic beat      = lnk.in_valid && lnk.in_ready;
  wire logic sof_seen  = SOF_OK && lnk.in_sof;
  wire logic take      = beat && !drop_first && (!SOF_OK || lnk.in_sof || cnt != '0);
  wire logic [AW-1:0] wr_idx = sof_seen ? '0 : cnt;
  wire logic load_done = take && (wr_idx == AW'(N - 1));

  // stage and drain control
  wire logic stage_end = (state == ffp_pkg::S_CALC) && (bidx == BW'(CPS - 1));
  wire logic calc_done = stage_end && (stage == GW'(LOG2N - 1));
  wire logic push      = (state == ffp_pkg::S_DUMP) && (fill != 2'(`FFP_FILL_MAX));
  wire logic pop       = lnk.out_valid && lnk.out_ready;
  wire logic dump_done = push && (cnt == AW'(N - 1));
  wire logic [AW-1:0] rd_idx = NATURAL ? cnt : bit_rev(cnt);

  // butterfly lanes: decimation in time on bit-reversed storage
  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    logic [BW-1:0]        j;
    logic [BW-1:0]        tk;
    logic signed [DW-1:0] a_re, a_im, x_re, x_im, t_re, t_im;
    logic signed [PW-1:0] p_re, p_im;
    logic signed [DW:0]   s_re, s_im, d_re, d_im;
    assign j  = BW'(int'(bidx) * LANES + l);
    assign tk = (j & ((BW'(1) << stage) - BW'(1))) << (GW'(LOG2N - 1) - stage);
    assign lt_addr[l] = pair_top(j, stage);
    assign lb_addr[l] = lt_addr[l] | (AW'(1) << stage);
    assign a_re = mem_re[lt_addr[l]];
    assign a_im = mem_im[lt_addr[l]];
    assign x_re = mem_re[lb_addr[l]];
    assign x_im = mem_im[lb_addr[l]];
    assign p_re = PW'(x_re) * PW'(tw_re[tk]) - PW'(x_im) * PW'(tw_im[tk]);
    assign p_im = PW'(x_re) * PW'(tw_im[tk]) + PW'(x_im) * PW'(tw_re[tk]);
    assign t_re = DW'(p_re >>> (TW_W - 2));
    assign t_im = DW'(p_im >>> (TW_W - 2));
    assign s_re = {a_re[DW-1], a_re} + {t_re[DW-1], t_re};
    assign s_im = {a_im[DW-1], a_im} + {t_im[DW-1], t_im};
    assign d_re = {a_re[DW-1], a_re} - {t_re[DW-1], t_re};
    assign d_im = {a_im[DW-1], a_im} - {t_im[DW-1], t_im};
    // halving every stage keeps |x| bounded by the input radius
    assign nt_re[l] = SCALED ? s_re[DW:1] : s_re[DW-1:0];
    assign nt_im[l] = SCALED ? s_im[DW:1] : s_im[DW-1:0];
    assign nb_re[l] = SCALED ? d_re[DW:1] : d_re[DW-1:0];
    assign nb_im[l] = SCALED ? d_im[DW:1] : d_im[DW-1:0];
  end

  // sequence of the engine
  always_comb
  begin
    next_state = state;
    unique case (state)
      ffp_pkg::S_LOAD: if (load_done) next_state = ffp_pkg::S_CALC;
      ffp_pkg::S_CALC: if (calc_done) next_state = ffp_pkg::S_DUMP;
      ffp_pkg::S_DUMP: if (dump_done) next_state = ffp_pkg::S_LOAD;
      default:         next_state = ffp_pkg::S_LOAD;
    endcase
  end

  // control registers, all on the rising edge of the one clock
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state      <= ffp_pkg::S_LOAD;
      cnt        <= '0;
      stage      <= '0;
      bidx       <= '0;
      drop_first <= 1'b1;
    end
    else
    begin
      state <= next_state;
      if (beat)
        drop_first <= 1'b0;
      if (take)
        cnt <= wr_idx + 1'b1;
      else if (push)
        cnt <= cnt + 1'b1;
      if (state == ffp_pkg::S_CALC)
        bidx <= stage_end ? '0 : bidx + 1'b1;
      if (stage_end)
        stage <= calc_done ? '0 : stage + 1'b1;
    end
  end

  // frame store; lanes touch disjoint words so the writes never collide
  always_ff @(posedge sys_clk)
  begin
    if (take)
    begin
      mem_re[bit_rev(wr_idx)] <= in_ext_re;
      mem_im[bit_rev(wr_idx)] <= in_ext_im;
    end
    if (state == ffp_pkg::S_CALC)
      for (int l = 0; l < LANES; l++)
      begin
        mem_re[lt_addr[l]] <= nt_re[l];
        mem_im[lt_addr[l]] <= nt_im[l];
        mem_re[lb_addr[l]] <= nb_re[l];
        mem_im[lb_addr[l]] <= nb_im[l];
      end
  end

  // two-entry output buffer: a stalled sink holds the drain, no word lost
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fill  <= '0;
      wp    <= 1'b0;
      rp    <= 1'b0;
      b_sof <= '0;
      for (int i = 0; i < 2; i++)
      begin
        b_re[i] <= '0;
        b_im[i] <= '0;
      end
    end
    else
    begin
      if (push)
      begin
        b_re[wp]  <= mem_re[rd_idx];
        b_im[wp]  <= mem_im[rd_idx];
        b_sof[wp] <= SOF_OK && (cnt == '0);
        wp        <= ~wp;
      end
      if (pop)
        rp <= ~rp;
      fill <= fill + 2'(push) - 2'(pop);
    end
  end

  assign lnk.out_valid = (fill != '0);
  assign lnk.out_re    = b_re[rp];
  assign lnk.out_im    = b_im[rp];
  assign lnk.out_sof   = lnk.out_valid && b_sof[rp];

  // edges from the last input beat taken to the first output shown
  assign latency    = 32'(LOG2N * CPS + 1);
  assign arch_burst = (ARCH == ffp_pkg::ARCH_BURST);

endmodule

// file: logic/ffp_cfg.svh
`ifndef FFP_CFG_SVH
`define FFP_CFG_SVH

// transform length as log2 of the point size
`define FFP_LOG2N_DEF   3
`define FFP_LOG2N_MIN   3
`define FFP_LOG2N_MAX   16

// sample, twiddle and stage counter widths
`define FFP_IN_W_DEF    16
`define FFP_TW_W        18
`define FFP_STAGE_W     5

// input period / system period that selects the burst engine
`define FFP_AREA_RATE   8

// single precision float fields
`define FFP_FLOAT_W     32
`define FFP_FLOAT_BIAS  127
`define FFP_FLOAT_MANT  23

// output buffer depth
`define FFP_FILL_MAX    2
`define FFP_PI          3.14159265358979

`endif

// file: logic/ffp_pkg.sv
package ffp_pkg;

  // engine sequence: gather a frame, run the stages, drain the frame
  typedef enum logic [1:0] {S_LOAD, S_CALC, S_DUMP} ffp_state_t;

  // architecture picked from the speed or area choice
  typedef enum logic {ARCH_STREAM, ARCH_BURST} ffp_arch_t;

endpackage

// file: logic/ffp_link.sv
`timescale 1ns/1ps

interface ffp_link
#(
  parameter int SW = 16,
  parameter int OW = 17
);
  // time-domain samples into the transform
  logic          in_valid;
  logic          in_ready;
  logic          in_sof;
  logic [SW-1:0] in_re;
  logic [SW-1:0] in_im;
  // frequency-domain samples out of the transform
  logic          out_valid;
  logic          out_ready;
  logic          out_sof;
  logic [OW-1:0] out_re;
  logic [OW-1:0] out_im;

  modport dev
  (
    input  in_valid, in_sof, in_re, in_im, out_ready,
    output in_ready, out_valid, out_sof, out_re, out_im
  );

  modport host
  (
    output in_valid, in_sof, in_re, in_im, out_ready,
    input  in_ready, out_valid, out_sof, out_re, out_im
  );
endinterface

// file: logic/ffp_host.sv
`timescale 1ns/1ps
`include "ffp_cfg.svh"

module ffp_host
#(
  parameter int LOG2N   = `FFP_LOG2N_DEF,
  parameter int SW      = `FFP_IN_W_DEF,
  parameter int OW      = `FFP_IN_W_DEF + 1,
  parameter bit USE_SOF = 1'b0
)
(
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  // link to the transform
  ffp_link.host              lnk,
  // user source
  input  wire logic          src_valid,
  output wire logic          src_ready,
  input  wire logic [SW-1:0] src_re,
  input  wire logic [SW-1:0] src_im,
  // user sink
  output wire logic          snk_valid,
  input  wire logic          snk_ready,
  output wire logic [OW-1:0] snk_re,
  output wire logic [OW-1:0] snk_im,
  output wire logic          snk_sof,
  output wire logic [LOG2N-1:0] snk_index
);

  localparam int N = 1 << LOG2N;

  logic             primed;
  logic [LOG2N-1:0] fcnt;
  logic [LOG2N-1:0] oidx;

  // one throw-away zero beat goes first, since the device may drop it
  assign lnk.in_valid = primed ? src_valid : 1'b1;
  assign lnk.in_re    = primed ? src_re : '0;
  assign lnk.in_im    = primed ? src_im : '0;
  assign src_ready    = primed && lnk.in_ready;
  assign lnk.in_sof   = USE_SOF && primed && (fcnt == '0);

  wire logic src_beat = src_valid && src_ready;
  wire logic out_beat = lnk.out_valid && lnk.out_ready;

  // sink side passes the device's registered data straight on
  assign snk_valid     = lnk.out_valid;
  assign lnk.out_ready = snk_ready;
  assign snk_re        = lnk.out_re;
  assign snk_im        = lnk.out_im;
  assign snk_sof       = lnk.out_sof;
  assign snk_index     = lnk.out_sof ? '0 : oidx;

  // frame position on both sides; the source wraps every N beats
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      primed <= 1'b0;
      fcnt   <= '0;
      oidx   <= '0;
    end
    else
    begin
      if (!primed && lnk.in_ready)
        primed <= 1'b1;
      if (src_beat)
        fcnt <= (fcnt == LOG2N'(N - 1)) ? '0 : fcnt + 1'b1;
      if (out_beat)
        oidx <= lnk.out_sof ? LOG2N'(1) : oidx + 1'b1;
    end
  end

endmodule

// file: verification/ffp_link_checker.sv
`timescale 1ns/1ps

// watches the link between host end and transform end
module ffp_link_checker
#(
  parameter int LOG2N = 3,
  parameter int SW    = 16,
  parameter int OW    = 17
)
(
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  // input stream
  input  wire logic          in_valid,
  input  wire logic          in_ready,
  input  wire logic          in_sof,
  input  wire logic [SW-1:0] in_re,
  input  wire logic [SW-1:0] in_im,
  // output stream
  input  wire logic          out_valid,
  input  wire logic          out_ready,
  input  wire logic          out_sof,
  input  wire logic [OW-1:0] out_re,
  input  wire logic [OW-1:0] out_im
);
  localparam int N = 1 << LOG2N;
  logic [31:0] acnt;
  logic [31:0] scnt;
  logic [31:0] ocnt;
  logic        seen;
  logic        first;
  wire logic   take;
  wire logic   pop;

  // handshakes on both streams
  assign take = in_valid && in_ready;
  assign pop  = out_valid && out_ready;

  // beat counters; seen skips the dummy beat sent before the first frame start
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acnt <= 32'h0;
      scnt <= 32'h0;
      ocnt <= 32'h0;
      seen  <= 1'b0;
      first <= 1'b1;
    end
    else
    begin
      acnt <= !in_ready ? 32'h0 : acnt + 32'(take);
      scnt <= !take ? scnt : (in_sof ? 32'h1 : scnt + 32'h1);
      seen <= seen || (take && in_sof);
      // only the very first beat after reset may be thrown away, so it carries nothing
      first <= first && !take;
      ocnt <= !pop ? ocnt : ((ocnt == N - 1) ? 32'h0 : ocnt + 32'h1);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_out_hold_stall: assert property (out_valid && !out_ready |=> out_valid && $stable(out_re)
    && $stable(out_im) && $stable(out_sof)) else $error("output word changed while stalled");
  a_sof_has_valid: assert property (out_sof |-> out_valid)
    else $error("output frame start without a word");
  a_sof_single_beat: assert property (out_sof && pop |=> !out_sof)
    else $error("output frame start longer than one word");
  a_sof_at_start: assert property (out_valid |-> out_sof == (ocnt == 0))
    else $error("output frame start not on first word");
  a_in_sof_spacing: assert property (take && in_sof && seen |-> scnt == N)
    else $error("input frame starts not one length apart");
  a_in_sof_pulse: assert property (take && in_sof |=> !in_sof)
    else $error("input frame start held past one beat");
  a_load_count: assert property ($fell(in_ready) |-> acnt >= N)
    else $error("load ended before a full frame");
  a_calc_hold: assert property ($fell(in_ready) |-> !in_ready [*8])
    else $error("input reopened during compute");
  a_first_answer: assert property ($fell(in_ready) |-> ##[5:8] out_valid)
    else $error("first output word late");
  a_first_filler: assert property (take && first |-> !in_sof && in_re == '0 && in_im == '0)
    else $error("first beat after reset is not a blank filler");
endmodule

// file: verification/fft_frame_processor_test.sv
`timescale 1ns/1ps
`include "ffp_cfg.svh"

// drives the host user side and checks every transformed frame
module fft_frame_processor_test;
  localparam int LOG2N   = 3;
  localparam int N       = 8;
  localparam bit SCALED  = 1'b1;
  localparam bit NAT     = 1'b1;
  localparam bit USE_SOF = 1'b1;
  localparam int SW      = 16;
  localparam int OW      = SW + (SCALED ? 1 : LOG2N + 1);
  localparam int TOL     = 4;
  logic             sys_clk;
  logic             arst_n;
  logic             src_valid;
  logic             src_ready;
  logic [SW-1:0]    src_re;
  logic [SW-1:0]    src_im;
  logic             snk_valid;
  logic             snk_ready;
  logic [OW-1:0]    snk_re;
  logic [OW-1:0]    snk_im;
  logic             snk_sof;
  logic [LOG2N-1:0] snk_index;
  logic [31:0]      latency;
  logic             arch_burst;
  int               error_cnt;
  int               compares;
  int               cycles;
  int               k;
  bit               stall;
  real              q_re[$];
  real              q_im[$];
  int               xr[N];
  int               xi[N];

  ffp_link #(.SW(SW), .OW(OW)) lnk ();
  ffp_core #(.LOG2N(LOG2N), .IN_W(SW), .IN_FRAC(SW - 1), .SCALED(SCALED), .NATURAL(NAT),
    .USE_SOF(USE_SOF)) u_ffp_core
    (.sys_clk(sys_clk), .arst_n(arst_n), .lnk(lnk), .latency(latency), .arch_burst(arch_burst));
  ffp_host #(.LOG2N(LOG2N), .SW(SW), .OW(OW), .USE_SOF(USE_SOF)) u_ffp_host
    (.sys_clk(sys_clk), .arst_n(arst_n), .lnk(lnk), .src_valid(src_valid),
    .src_ready(src_ready), .src_re(src_re), .src_im(src_im), .snk_valid(snk_valid),
    .snk_ready(snk_ready), .snk_re(snk_re), .snk_im(snk_im), .snk_sof(snk_sof),
    .snk_index(snk_index));
  ffp_link_checker #(.LOG2N(LOG2N), .SW(SW), .OW(OW)) u_chk
    (.sys_clk(sys_clk), .arst_n(arst_n), .in_valid(lnk.in_valid), .in_ready(lnk.in_ready),
    .in_sof(lnk.in_sof), .in_re(lnk.in_re), .in_im(lnk.in_im), .out_valid(lnk.out_valid),
    .out_ready(lnk.out_ready), .out_sof(lnk.out_sof), .out_re(lnk.out_re),
    .out_im(lnk.out_im));

  // 25 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic final_report();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // truncation in each stage biases results, so values match within a few steps
  task automatic cmp_near(input logic [OW-1:0] got, input real exp);
    real d;
    d = $itor($signed(got)) - exp;
    compares++;
    if ((^got === 1'bx) || d > TOL || d < -TOL)
    begin
      error_cnt++;
      $display("wrong value at %0t: sample %0d expected %0f", $time, $signed(got), exp);
    end
  endtask

  task automatic cmp_bits(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: flag %0h expected %0h", $time, got, exp);
    end
  endtask

  // output position p carries bin p in natural order, else the bit-reversed bin
  function automatic int out_bin(input int p);
    int b;
    b = 0;
    for (int i = 0; i < LOG2N; i++)
      b = (b << 1) | ((p >> i) & 1);
    return NAT ? p : b;
  endfunction

  // mode 0 impulse, 1 extreme constant, else random; expectation is the dft,
  // divided by N when scaled, queued in the order the bins leave the core
  task automatic send_frame(input int mode);
    real         ar;
    real         ai;
    real         ang;
    logic [15:0] r;
    for (int n = 0; n < N; n++)
    begin
      r = 16'($urandom);
      xr[n] = (mode == 0) ? ((n == 0) ? 16384 : 0) : (mode == 1) ? -32768 : $signed(r);
      r = 16'($urandom);
      xi[n] = (mode == 0) ? 0 : (mode == 1) ? 32767 : $signed(r);
    end
    for (int p = 0; p < N; p++)
    begin
      ar = 0.0;
      ai = 0.0;
      for (int n = 0; n < N; n++)
      begin
        ang = 2.0 * `FFP_PI * n * out_bin(p) / N;
        ar = ar + xr[n] * $cos(ang) + xi[n] * $sin(ang);
        ai = ai + xi[n] * $cos(ang) - xr[n] * $sin(ang);
      end
      q_re.push_back(SCALED ? ar / N : ar);
      q_im.push_back(SCALED ? ai / N : ai);
    end
    for (int n = 0; n < N; n++)
    begin
      if ($urandom % 4 == 0)
      begin
        src_valid <= 1'b0;
        @(posedge sys_clk);
      end
      src_valid <= 1'b1;
      src_re    <= SW'(xr[n]);
      src_im    <= SW'(xi[n]);
      do @(negedge sys_clk); while (src_ready !== 1'b1);
      @(posedge sys_clk);
    end
  endtask

  // sink pacing: random stalls, or a long stall that fills the buffer
  initial
  begin
    snk_ready = 1'b0;
    forever
    begin
      @(posedge sys_clk);
      snk_ready <= !stall && ($urandom % 3 != 0);
    end
  end

  // each accepted word against the oldest expectation, in natural order
  always @(negedge sys_clk)
  begin
    if (snk_valid === 1'b1 && snk_ready === 1'b1)
    begin
      if (q_re.size() == 0)
        cmp_bits(32'(snk_valid), 32'h0);
      else
      begin
        cmp_near(snk_re, q_re.pop_front());
        cmp_near(snk_im, q_im.pop_front());
        cmp_bits(32'(snk_index), 32'(k));
        cmp_bits(32'(snk_sof), 32'(USE_SOF && k == 0));
        k = (k + 1) % N;
      end
    end
  end

  // hang guard, far above the well under a thousand cycles the run needs
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      error_cnt++;
      final_report();
    end
  end

  // main sequence
  initial
  begin
    arst_n    = 1'b0;
    src_valid = 1'b0;
    src_re    = 16'h0000;
    src_im    = 16'h0000;
    stall     = 1'b0;
    void'($urandom(32'hD13B0CB5));
    repeat (16) @(posedge sys_clk);
    cmp_bits(32'(snk_valid), 32'h0);
    cmp_bits(latency, 32'(LOG2N * (N / 4) + 1));
    cmp_bits(32'(arch_burst), 32'h0);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    send_frame(0);
    send_frame(1);
    stall = 1'b1;
    repeat (40) @(posedge sys_clk);
    @(negedge sys_clk);
    cmp_bits(32'(snk_valid), 32'h1);
    cmp_bits(32'(src_ready), 32'h0);
    stall = 1'b0;
    @(posedge sys_clk);
    for (int f = 0; f < 20; f++)
      send_frame(2);
    src_valid <= 1'b0;
    for (int i = 0; i < 400 && q_re.size() != 0; i++)
      @(posedge sys_clk);
    cmp_bits(32'(q_re.size()), 32'h0);
    final_report();
  end
endmodule
